// ---- common/fcd_map.svh ----
// fcd_map.svh: addresses, command codes and bus timing of the flash command sequencer
// assumes a 125 MHz host clock; counts derive from the times below
`ifndef FCD_MAP_SVH
`define FCD_MAP_SVH
`define FCD_AW 19
`define FCD_DW 16
`define FCD_CNT_W 4
`define FCD_U1_WORD 19'h00555
`define FCD_U2_WORD 19'h002AA
`define FCD_U1_BYTE 19'h00AAA
`define FCD_U2_BYTE 19'h00555
`define FCD_ANY_ADDR 19'h00000
`define FCD_C_UNLOCK1 8'hAA
`define FCD_C_UNLOCK2 8'h55
`define FCD_C_AUTOSEL 8'h90
`define FCD_C_PROGRAM 8'hA0
`define FCD_C_BYPASS 8'h20
`define FCD_C_ERASE_SETUP 8'h80
`define FCD_C_CHIP 8'h10
`define FCD_C_SECTOR 8'h30
`define FCD_C_SUSPEND 8'hB0
`define FCD_C_RESUME 8'h30
`define FCD_C_RESET 8'hF0
`define FCD_C_BYP_EXIT1 8'h90
`define FCD_C_BYP_EXIT2 8'h00
`define FCD_UPPER_ZERO 8'h00
`define FCD_TL_BIT 5
`define FCD_CLK_PS 8000
`define FCD_T_WP_NS 35
`define FCD_T_WPH_NS 30
`define FCD_T_ACC_NS 70
`define FCD_WP_CYC ((`FCD_T_WP_NS * 1000 + `FCD_CLK_PS - 1) / `FCD_CLK_PS)
`define FCD_WPH_CYC ((`FCD_T_WPH_NS * 1000 + `FCD_CLK_PS - 1) / `FCD_CLK_PS)
`define FCD_ACC_CYC ((`FCD_T_ACC_NS * 1000 + `FCD_CLK_PS - 1) / `FCD_CLK_PS)
`endif

// ---- common/fcd_pkg.sv ----
// fcd_pkg: types of the flash command sequencer
// assumes fcd_map.svh supplies widths
`include "fcd_map.svh"
package fcd_pkg;
   typedef enum logic [3:0] {
      FCD_OP_READ = 4'h0,
      FCD_OP_STATUS = 4'h1,
      FCD_OP_RESET = 4'h2,
      FCD_OP_AUTOSEL = 4'h3,
      FCD_OP_PROGRAM = 4'h4,
      FCD_OP_BYP_ENTER = 4'h5,
      FCD_OP_BYP_PROG = 4'h6,
      FCD_OP_BYP_EXIT = 4'h7,
      FCD_OP_CHIP_ERASE = 4'h8,
      FCD_OP_SECTOR_ERASE = 4'h9,
      FCD_OP_SECTOR_ADD = 4'hA,
      FCD_OP_SUSPEND = 4'hB,
      FCD_OP_RESUME = 4'hC
   } fcd_op_t;
   typedef enum logic [2:0] {
      FCD_ST_IDLE = 3'h0,
      FCD_ST_SETUP = 3'h1,
      FCD_ST_PULSE = 3'h3,
      FCD_ST_HOLD = 3'h2,
      FCD_ST_READ = 3'h5
   } fcd_state_t;
   typedef struct packed {
      fcd_op_t op;
      logic [`FCD_AW-1:0] addr;
      logic [`FCD_DW-1:0] data;
      logic byte_mode;
   } fcd_req_t;
   typedef struct packed {
      logic [`FCD_AW-1:0] addr;
      logic [`FCD_DW-1:0] data;
      logic rd;
   } fcd_step_t;
endpackage

// ---- dv/fcd_flash_model.sv ----
// fcd_flash_model: behavioural NOR flash that answers the sequencer's bus cycles
// assumes ce and we rise together at the end of each write; read data follows after DLY_NS
`timescale 1ns/1ps
module fcd_flash_model #(
   parameter logic [15:0] MAKER_ID = 16'h00C5, // arbitrary value
   parameter logic [15:0] DEV_ID = 16'h7E3C, // arbitrary value
   parameter logic [5:0] PROT_SEC = 6'h03,
   parameter int DLY_NS = 20
) (
   input wire logic [18:0] fl_addr_in,
   input wire logic [15:0] fl_dq_in,
   input wire logic fl_ce_n_in,
   input wire logic fl_we_n_in,
   input wire logic fl_oe_n_in,
   input wire logic fl_byte_n_in,
   input wire logic tl_in,
   output logic [15:0] dq_out,
   output logic [3:0] st_out
);
   logic [15:0] mem [0:15];
   logic [15:0] rd;
   logic [15:0] rd_q = 16'h0000;
   logic [18:0] la = '0;
   logic [17:0] wa;
   logic act = 1'b0, pp = 1'b0, byp = 1'b0, bx = 1'b0, auto = 1'b0, ers = 1'b0, sus = 1'b0;
   int seq = 0;
   assign wa = fl_byte_n_in ? fl_addr_in[17:0] : fl_addr_in[18:1];
   assign st_out = {sus, ers, byp, auto};
   initial for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
   task automatic wr(input logic [15:0] d);
      logic [7:0] c;
      logic [11:0] a;
      logic h1, h2;
      c = d[7:0];
      a = fl_byte_n_in ? {1'b0, la[10:0]} : la[11:0];
      h1 = (a == (fl_byte_n_in ? 12'h555 : 12'hAAA));
      h2 = (a == (fl_byte_n_in ? 12'h2AA : 12'h555));
      if (pp) begin
         mem[fl_byte_n_in ? la[3:0] : la[4:1]] = d;
         pp = 1'b0;
      end else if (byp) begin
         pp = !bx && (c == 8'hA0);
         byp = !(bx && c == 8'h00);
         bx = !bx && (c == 8'h90);
      end else if (c == 8'hF0) begin
         auto = 1'b0;
         ers = ers & sus;
         seq = 0;
      end else if (seq == 0 && ers && c == 8'hB0) begin
         sus = 1'b1;
      end else if (seq == 0 && ers && c == 8'h30) begin
         sus = 1'b0;
      end else begin
         case (seq)
            0: seq = (c == 8'hAA && h1) ? 1 : 0;
            1: seq = (c == 8'h55 && h2) ? 2 : 0;
            2: begin
               seq = (c == 8'h80 && h1) ? 3 : 0;
               auto = auto | (c == 8'h90 && h1);
               pp = (c == 8'hA0 && h1);
               byp = (c == 8'h20 && h1);
            end
            3: seq = (c == 8'hAA && h1) ? 4 : 0;
            4: seq = (c == 8'h55 && h2) ? 5 : 0;
            default: begin
               ers = ers | (c == 8'h30);
               seq = 0;
            end
         endcase
      end
   endtask
   always @(negedge fl_we_n_in or negedge fl_ce_n_in)
      if (!fl_we_n_in && !fl_ce_n_in) begin
         la = fl_addr_in;
         act = 1'b1;
      end
   always @(posedge fl_we_n_in or posedge fl_ce_n_in)
      if (act) begin
         act = 1'b0;
         wr(fl_dq_in);
      end
   always_comb begin
      rd = mem[wa[3:0]];
      if (ers && !sus)
         rd = tl_in ? 16'h0020 : 16'h0040;
      if (auto)
         case (wa[7:0])
            8'h00: rd = MAKER_ID;
            8'h01: rd = DEV_ID;
            8'h02: rd = {15'h0000, wa[17:12] == PROT_SEC};
            default: ;
         endcase
      if (!fl_byte_n_in)
         rd[15:8] = 8'h00;
   end
   // released bus shows the inverse of the last value, never a stale match
   always @(posedge fl_oe_n_in or posedge fl_ce_n_in) rd_q = rd;
   assign #(DLY_NS) dq_out = (!fl_ce_n_in && !fl_oe_n_in) ? rd : ~rd_q;
endmodule

// ---- dv/fcd_monitor.sv ----
// fcd_monitor: pin timing and refusal checks of the flash command sequencer
// assumes binding to fcd_host_ctrl; single clock domain
`timescale 1ns/1ps
`include "fcd_map.svh"
module fcd_monitor
   import fcd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic req_valid_in,
   input wire fcd_req_t req_in,
   input wire logic req_ready_out,
   input wire logic refused_out,
   input wire logic bypass_out,
   input wire logic suspended_out,
   input wire logic [`FCD_AW-1:0] fl_addr_out,
   input wire logic [`FCD_DW-1:0] fl_dq_out,
   input wire logic fl_dq_oe_out,
   input wire logic fl_ce_n_out,
   input wire logic fl_we_n_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic take;
   assign take = req_valid_in && req_ready_out;
   property p_refuse_quiet; refused_out |-> fl_ce_n_out && fl_we_n_out && !fl_dq_oe_out; endproperty
   a_refuse_quiet: assert property (p_refuse_quiet) else $error("pins moved on refusal");
   property p_we_width; $fell(fl_we_n_out) |-> (!fl_we_n_out && !fl_ce_n_out && fl_dq_oe_out)[*5] ##1 fl_we_n_out;
   endproperty
   a_we_width: assert property (p_we_width) else $error("bad write strobe");
   property p_data_hold; !fl_we_n_out ##1 fl_we_n_out |-> $stable(fl_dq_out) && fl_dq_oe_out; endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved at strobe rise");
   property p_addr_stable; !fl_we_n_out ##1 !fl_we_n_out |-> $stable(fl_addr_out) && $stable(fl_dq_out); endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address moved in strobe");
   property p_byp_refuse; take && bypass_out && !(req_in.op inside {FCD_OP_READ, FCD_OP_STATUS,
      FCD_OP_BYP_PROG, FCD_OP_BYP_EXIT}) |=> refused_out; endproperty
   a_byp_refuse: assert property (p_byp_refuse) else $error("bypass took other command");
   property p_resume_refuse; take && !suspended_out && req_in.op == FCD_OP_RESUME |=> refused_out; endproperty
   a_resume_refuse: assert property (p_resume_refuse) else $error("resume taken when not suspended");
   property p_susp_refuse; take && suspended_out && req_in.op == FCD_OP_SUSPEND |=> refused_out; endproperty
   a_susp_refuse: assert property (p_susp_refuse) else $error("suspend taken when suspended");
   property p_reset_cmd; take && !bypass_out && req_in.op == FCD_OP_RESET |=>
      ##[0:3] (!fl_ce_n_out && fl_dq_oe_out && fl_dq_out == 16'h00F0); endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset write missing");
endmodule
bind fcd_host_ctrl fcd_monitor MON (.clk_in, .rst_n_in, .req_valid_in, .req_in, .req_ready_out, .refused_out,
   .bypass_out, .suspended_out, .fl_addr_out, .fl_dq_out, .fl_dq_oe_out, .fl_ce_n_out, .fl_we_n_out);

// ---- dv/tb_top.sv ----
// tb_top: directed bench of the flash command sequencer against a flash model
// assumes 125 MHz clock; inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`include "fcd_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_top;
   import fcd_pkg::*;
   localparam logic [15:0] ID_MAKER = 16'h00C5; // arbitrary value
   localparam logic [15:0] ID_DEV = 16'h7E3C; // arbitrary value
   localparam logic [5:0] PROT_SEC = 6'h03;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic req_valid_in = 1'b0;
   fcd_req_t req_in = '0;
   logic tl_in = 1'b0;
   logic bm = 1'b0;
   logic req_ready_out, done_out, refused_out, time_limit_flag_out, bypass_out, suspended_out, autosel_out;
   logic fl_dq_oe_out, fl_ce_n_out, fl_we_n_out, fl_oe_n_out, fl_byte_n_out;
   logic [`FCD_DW-1:0] rd_data_out, fl_dq_out, fl_dq_in;
   logic [`FCD_AW-1:0] fl_addr_out;
   logic [3:0] st;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   always #4 clk_in = ~clk_in;
   fcd_host_ctrl DUT (
      .clk_in, .rst_n_in, .req_valid_in, .req_in, .req_ready_out, .done_out, .refused_out,
      .rd_data_out, .time_limit_flag_out, .bypass_out, .suspended_out, .autosel_out,
      .fl_addr_out, .fl_dq_out, .fl_dq_oe_out, .fl_dq_in, .fl_ce_n_out, .fl_we_n_out,
      .fl_oe_n_out, .fl_byte_n_out
   );
   fcd_flash_model #(.MAKER_ID(ID_MAKER), .DEV_ID(ID_DEV), .PROT_SEC(PROT_SEC)) FLASH (
      .fl_addr_in(fl_addr_out), .fl_dq_in(fl_dq_out), .fl_ce_n_in(fl_ce_n_out), .fl_we_n_in(fl_we_n_out),
      .fl_oe_n_in(fl_oe_n_out), .fl_byte_n_in(fl_byte_n_out), .tl_in, .dq_out(fl_dq_in), .st_out(st)
   );
   task automatic results;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // one request; waits for done or refusal and checks which came
   task automatic req(input fcd_op_t op, input logic [18:0] a, input logic [15:0] d, input logic rf);
      int n;
      @(posedge clk_in);
      #1;
      req_in = '{op, a, d, bm};
      req_valid_in = 1'b1;
      @(posedge clk_in);
      #1;
      req_valid_in = 1'b0;
      n = 0;
      while (done_out !== 1'b1 && refused_out !== 1'b1 && n < 400) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      `CHK({done_out, refused_out}, {~rf, rf})
   endtask
   task automatic t_reset;
      `CHK({req_ready_out, fl_ce_n_out, fl_we_n_out, fl_oe_n_out, fl_dq_oe_out, fl_byte_n_out}, 6'b111101)
   endtask
   task automatic t_prog;
      req(FCD_OP_READ, 19'h00005, 16'h0000, 1'b0);
      `CHK(rd_data_out, 16'hFFFF)
      req(FCD_OP_PROGRAM, 19'h3F805, 16'hA55A, 1'b0);
      req(FCD_OP_READ, 19'h00005, 16'h0000, 1'b0);
      `CHK(rd_data_out, 16'hA55A)
   endtask
   task automatic t_auto;
      bm = 1'b1;
      req(FCD_OP_AUTOSEL, 19'h00000, 16'h0000, 1'b0);
      `CHK(rd_data_out, {8'h00, ID_MAKER[7:0]})
      bm = 1'b0;
      req(FCD_OP_AUTOSEL, {1'b0, PROT_SEC, 12'h002}, 16'h0000, 1'b0);
      `CHK(rd_data_out, 16'h0001)
      req(FCD_OP_READ, 19'h01002, 16'h0000, 1'b0);
      `CHK(rd_data_out, 16'h0000)
      req(FCD_OP_RESET, 19'h00000, 16'h0000, 1'b0);
      `CHK({autosel_out, st}, 5'b00000)
   endtask
   task automatic t_byp;
      req(FCD_OP_BYP_PROG, 19'h00007, 16'h1234, 1'b1);
      req(FCD_OP_BYP_ENTER, 19'h00000, 16'h0000, 1'b0);
      `CHK({bypass_out, st}, 5'b10010)
      req(FCD_OP_BYP_PROG, 19'h00007, 16'h1234, 1'b0);
      req(FCD_OP_PROGRAM, 19'h00007, 16'h0000, 1'b1);
      req(FCD_OP_BYP_EXIT, 19'h00000, 16'h0000, 1'b0);
      `CHK({bypass_out, st}, 5'b00000)
      req(FCD_OP_READ, 19'h00007, 16'h0000, 1'b0);
      `CHK(rd_data_out, 16'h1234)
   endtask
   task automatic t_erase;
      req(FCD_OP_SUSPEND, 19'h00000, 16'h0000, 1'b1);
      req(FCD_OP_RESUME, 19'h00000, 16'h0000, 1'b1);
      req(FCD_OP_SECTOR_ERASE, 19'h02000, 16'h0000, 1'b0);
      `CHK(st, 4'b0100)
      req(FCD_OP_SECTOR_ADD, 19'h03000, 16'h0000, 1'b0);
      req(FCD_OP_SUSPEND, 19'h00000, 16'h0000, 1'b0);
      `CHK({suspended_out, st}, 5'b11100)
      req(FCD_OP_SUSPEND, 19'h00000, 16'h0000, 1'b1);
      req(FCD_OP_PROGRAM, 19'h00009, 16'h0BEE, 1'b0);
      req(FCD_OP_READ, 19'h00009, 16'h0000, 1'b0);
      `CHK(rd_data_out, 16'h0BEE)
      req(FCD_OP_AUTOSEL, 19'h02001, 16'h0000, 1'b0);
      `CHK(rd_data_out, ID_DEV)
      req(FCD_OP_RESET, 19'h00000, 16'h0000, 1'b0);
      `CHK({autosel_out, suspended_out, st}, 6'b011100)
      req(FCD_OP_RESUME, 19'h00000, 16'h0000, 1'b0);
      `CHK({suspended_out, st}, 5'b00100)
      req(FCD_OP_RESUME, 19'h00000, 16'h0000, 1'b1);
      req(FCD_OP_SUSPEND, 19'h00000, 16'h0000, 1'b0);
      `CHK(st, 4'b1100)
      req(FCD_OP_RESUME, 19'h00000, 16'h0000, 1'b0);
   endtask
   task automatic t_status;
      req(FCD_OP_CHIP_ERASE, 19'h00000, 16'h0000, 1'b0);
      req(FCD_OP_SUSPEND, 19'h00000, 16'h0000, 1'b1);
      tl_in = 1'b1;
      req(FCD_OP_STATUS, 19'h02000, 16'h0000, 1'b0);
      `CHK({time_limit_flag_out, st, rd_data_out}, {5'b10000, 16'h0020})
      tl_in = 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      t_reset();
      t_prog();
      t_auto();
      t_byp();
      t_erase();
      t_status();
      results();
   end
   // about 30 requests of under 70 cycles each
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         results();
      end
   end
endmodule

// ---- rtl/fcd_host_ctrl.sv ----
// fcd_host_ctrl: host that drives a NOR flash through its bus pins as command sequences
// assumes flash pins are sampled synchronously to clk_in; one request at a time
// Function
// - write F0 to leave autoselect, or when time limit flag rises on status.
// - autoselect is AA,55,90 at unlock addresses, then a read.
// - program is two unlocks, A0, then address and data.
// - AA,55,20 enters bypass; then A0 and address/data program.
// - leave bypass by writing 90 then 00 at any address.
// - erase is AA,55,80,AA,55 then 10 chip or sector address 30.
// - every command cycle except reads is a bus write.
`timescale 1ns/1ps
`include "fcd_map.svh"
module fcd_host_ctrl
   import fcd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic req_valid_in,
   input wire fcd_req_t req_in,
   output logic req_ready_out,
   output logic done_out,
   output logic refused_out,
   output logic [`FCD_DW-1:0] rd_data_out,
   output logic time_limit_flag_out,
   output logic bypass_out,
   output logic suspended_out,
   output logic autosel_out,
   output logic [`FCD_AW-1:0] fl_addr_out,
   output logic [`FCD_DW-1:0] fl_dq_out,
   output logic fl_dq_oe_out,
   input wire logic [`FCD_DW-1:0] fl_dq_in,
   output logic fl_ce_n_out,
   output logic fl_we_n_out,
   output logic fl_oe_n_out,
   output logic fl_byte_n_out
);
   localparam logic [`FCD_CNT_W-1:0] WP_LAST = `FCD_CNT_W'(`FCD_WP_CYC - 1);
   localparam logic [`FCD_CNT_W-1:0] WPH_LAST = `FCD_CNT_W'(`FCD_WPH_CYC - 1);
   localparam logic [`FCD_CNT_W-1:0] ACC_LAST = `FCD_CNT_W'(`FCD_ACC_CYC - 1);

   // one bus cycle of a sequence; command cycles carry a zero upper byte; unlock cycles use the fixed unlock addresses
   function automatic fcd_step_t seq_step(input fcd_op_t op, input logic [2:0] idx, input fcd_req_t r);
      logic [`FCD_AW-1:0] u1;
      logic [`FCD_AW-1:0] u2;
      fcd_step_t s;
      u1 = r.byte_mode ? `FCD_U1_BYTE : `FCD_U1_WORD;
      u2 = r.byte_mode ? `FCD_U2_BYTE : `FCD_U2_WORD;
      s.rd = 1'b0;
      s.addr = `FCD_ANY_ADDR;
      s.data = {`FCD_UPPER_ZERO, `FCD_C_RESET};
      unique case (idx)
         3'h0: begin
            s.addr = u1;
            s.data = {`FCD_UPPER_ZERO, `FCD_C_UNLOCK1};
         end
         3'h1: begin
            s.addr = u2;
            s.data = {`FCD_UPPER_ZERO, `FCD_C_UNLOCK2};
         end
         3'h2: s.addr = u1;
         3'h3: begin
            s.addr = u1;
            s.data = {`FCD_UPPER_ZERO, `FCD_C_UNLOCK1};
         end
         3'h4: begin
            s.addr = u2;
            s.data = {`FCD_UPPER_ZERO, `FCD_C_UNLOCK2};
         end
         default: s.addr = u1;
      endcase
      unique case (op)
         FCD_OP_READ, FCD_OP_STATUS: begin
            s.addr = r.addr;
            s.rd = 1'b1;
         end
         FCD_OP_RESET: begin
            s.addr = `FCD_ANY_ADDR;
            s.data = {`FCD_UPPER_ZERO, `FCD_C_RESET};
         end
         FCD_OP_AUTOSEL: begin
            if (idx == 3'h2) s.data = {`FCD_UPPER_ZERO, `FCD_C_AUTOSEL};
            if (idx == 3'h3) begin
               s.addr = r.addr;
               s.rd = 1'b1;
            end
         end
         FCD_OP_PROGRAM: begin
            if (idx == 3'h2) s.data = {`FCD_UPPER_ZERO, `FCD_C_PROGRAM};
            if (idx == 3'h3) begin
               s.addr = r.addr;
               s.data = r.data;
            end
         end
         FCD_OP_BYP_ENTER: if (idx == 3'h2) s.data = {`FCD_UPPER_ZERO, `FCD_C_BYPASS};
         FCD_OP_BYP_PROG: begin
            s.addr = (idx == 3'h0) ? `FCD_ANY_ADDR : r.addr;
            s.data = (idx == 3'h0) ? {`FCD_UPPER_ZERO, `FCD_C_PROGRAM} : r.data;
         end
         FCD_OP_BYP_EXIT: begin
            s.addr = `FCD_ANY_ADDR;
            s.data = {`FCD_UPPER_ZERO, (idx == 3'h0) ? `FCD_C_BYP_EXIT1 : `FCD_C_BYP_EXIT2};
         end
         FCD_OP_CHIP_ERASE, FCD_OP_SECTOR_ERASE: begin
            if (idx == 3'h2) s.data = {`FCD_UPPER_ZERO, `FCD_C_ERASE_SETUP};
            if (idx == 3'h5) begin
               s.addr = (op == FCD_OP_CHIP_ERASE) ? u1 : r.addr;
               s.data = {`FCD_UPPER_ZERO, (op == FCD_OP_CHIP_ERASE) ? `FCD_C_CHIP : `FCD_C_SECTOR};
            end
         end
         FCD_OP_SECTOR_ADD: begin
            s.addr = r.addr;
            s.data = {`FCD_UPPER_ZERO, `FCD_C_SECTOR};
         end
         FCD_OP_SUSPEND: begin
            s.addr = `FCD_ANY_ADDR;
            s.data = {`FCD_UPPER_ZERO, `FCD_C_SUSPEND};
         end
         FCD_OP_RESUME: begin
            s.addr = `FCD_ANY_ADDR;
            s.data = {`FCD_UPPER_ZERO, `FCD_C_RESUME};
         end
         default: s.rd = 1'b0;
      endcase
      return s;
   endfunction

   function automatic logic [2:0] seq_len(input fcd_op_t op);
      unique case (op)
         FCD_OP_AUTOSEL, FCD_OP_PROGRAM: seq_len = 3'h4;
         FCD_OP_BYP_ENTER: seq_len = 3'h3;
         FCD_OP_BYP_PROG, FCD_OP_BYP_EXIT: seq_len = 3'h2;
         FCD_OP_CHIP_ERASE, FCD_OP_SECTOR_ERASE: seq_len = 3'h6;
         default: seq_len = 3'h1;
      endcase
   endfunction

   fcd_state_t state_ff, nxt_state;
   fcd_op_t op_ff, nxt_op;
   fcd_req_t req_ff, nxt_req;
   logic [2:0] idx_ff, nxt_idx;
   logic [`FCD_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic bypass_ff, nxt_bypass, susp_ff, nxt_susp, auto_ff, nxt_auto, erasing_ff, nxt_erasing;
   logic ready_ff, nxt_ready, done_ff, nxt_done, refused_ff, nxt_refused, tl_ff, nxt_tl;
   logic [`FCD_DW-1:0] rdata_ff, nxt_rdata, dq_ff, nxt_dq;
   logic [`FCD_AW-1:0] addr_ff, nxt_addr;
   logic dq_oe_ff, nxt_dq_oe, ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n, byte_n_ff, nxt_byte_n;
   fcd_step_t step;
   logic refuse;

   always_comb begin
      step = seq_step(op_ff, idx_ff, req_ff);
      // requests that would only be ignored or misread by the flash are turned away here
      refuse = 1'b0;
      unique case (req_in.op)
         FCD_OP_READ, FCD_OP_STATUS: refuse = 1'b0;
         FCD_OP_BYP_PROG, FCD_OP_BYP_EXIT: refuse = !bypass_ff;
         FCD_OP_RESUME: refuse = bypass_ff || !susp_ff;
         FCD_OP_SUSPEND: refuse = bypass_ff || !erasing_ff || susp_ff;
         FCD_OP_SECTOR_ADD: refuse = bypass_ff || !erasing_ff || susp_ff;
         FCD_OP_CHIP_ERASE, FCD_OP_SECTOR_ERASE, FCD_OP_BYP_ENTER: refuse = bypass_ff || susp_ff;
         default: refuse = bypass_ff;
      endcase
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_req = req_ff;
      nxt_idx = idx_ff;
      nxt_cnt = cnt_ff;
      nxt_bypass = bypass_ff;
      nxt_susp = susp_ff;
      nxt_auto = auto_ff;
      nxt_erasing = erasing_ff;
      nxt_done = 1'b0;
      nxt_refused = 1'b0;
      nxt_tl = tl_ff;
      nxt_rdata = rdata_ff;
      nxt_dq = dq_ff;
      nxt_addr = addr_ff;
      nxt_dq_oe = dq_oe_ff;
      nxt_ce_n = ce_n_ff;
      nxt_we_n = we_n_ff;
      nxt_oe_n = oe_n_ff;
      nxt_byte_n = byte_n_ff;
      unique case (state_ff)
         FCD_ST_IDLE: begin
            if (req_valid_in && refuse) begin
               nxt_refused = 1'b1;
            end else if (req_valid_in) begin
               nxt_op = req_in.op;
               nxt_req = req_in;
               nxt_idx = 3'h0;
               nxt_byte_n = !req_in.byte_mode;
               nxt_state = FCD_ST_SETUP;
            end
         end
         FCD_ST_SETUP: begin
            nxt_addr = step.addr;
            nxt_ce_n = 1'b0;
            if (step.rd) begin
               nxt_dq_oe = 1'b0;
               nxt_oe_n = 1'b0;
               nxt_cnt = ACC_LAST;
               nxt_state = FCD_ST_READ;
            end else begin
               nxt_dq = step.data;
               nxt_dq_oe = 1'b1;
               nxt_cnt = WP_LAST;
               nxt_state = FCD_ST_PULSE;
            end
         end
         FCD_ST_PULSE: begin
            // the count only runs once the strobe is low, so it stays low for the full WP_LAST+1 cycles
            nxt_we_n = 1'b0;
            if (!we_n_ff) nxt_cnt = cnt_ff - 1'b1;
            if (!we_n_ff && cnt_ff == '0) begin
               nxt_we_n = 1'b1;
               nxt_ce_n = 1'b1;
               nxt_cnt = WPH_LAST;
               nxt_state = FCD_ST_HOLD;
            end
         end
         FCD_ST_READ: begin
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == '0) begin
               nxt_rdata = fl_dq_in;
               nxt_oe_n = 1'b1;
               nxt_ce_n = 1'b1;
               nxt_cnt = WPH_LAST;
               nxt_state = FCD_ST_HOLD;
            end
         end
         FCD_ST_HOLD: begin
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == '0) begin
               nxt_dq_oe = 1'b0;
               nxt_idx = idx_ff + 3'h1;
               nxt_state = FCD_ST_SETUP;
               if (idx_ff + 3'h1 == seq_len(op_ff)) begin
                  nxt_state = FCD_ST_IDLE;
                  nxt_done = 1'b1;
                  unique case (op_ff)
                     FCD_OP_STATUS: begin
                        nxt_tl = rdata_ff[`FCD_TL_BIT];
                        if (rdata_ff[`FCD_TL_BIT]) begin
                           nxt_op = FCD_OP_RESET;
                           nxt_idx = 3'h0;
                           nxt_done = 1'b0;
                           nxt_state = FCD_ST_SETUP;
                        end
                     end
                     FCD_OP_AUTOSEL: nxt_auto = 1'b1;
                     FCD_OP_RESET: begin
                        nxt_auto = 1'b0;
                        nxt_erasing = susp_ff && erasing_ff;
                     end
                     FCD_OP_BYP_ENTER: nxt_bypass = 1'b1;
                     FCD_OP_BYP_EXIT: nxt_bypass = 1'b0;
                     FCD_OP_SECTOR_ERASE: nxt_erasing = 1'b1;
                     FCD_OP_CHIP_ERASE: nxt_erasing = 1'b0;
                     FCD_OP_SUSPEND: nxt_susp = 1'b1;
                     FCD_OP_RESUME: nxt_susp = 1'b0;
                     default: nxt_auto = auto_ff;
                  endcase
               end
            end
         end
         default: nxt_state = FCD_ST_IDLE;
      endcase
      nxt_ready = (nxt_state == FCD_ST_IDLE);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= FCD_ST_IDLE;
         op_ff <= FCD_OP_READ;
         req_ff <= '0;
         idx_ff <= 3'h0;
         cnt_ff <= '0;
         bypass_ff <= 1'b0;
         susp_ff <= 1'b0;
         auto_ff <= 1'b0;
         erasing_ff <= 1'b0;
         ready_ff <= 1'b1;
         done_ff <= 1'b0;
         refused_ff <= 1'b0;
         tl_ff <= 1'b0;
         rdata_ff <= '0;
         dq_ff <= '0;
         addr_ff <= '0;
         dq_oe_ff <= 1'b0;
         ce_n_ff <= 1'b1;
         we_n_ff <= 1'b1;
         oe_n_ff <= 1'b1;
         byte_n_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         req_ff <= nxt_req;
         idx_ff <= nxt_idx;
         cnt_ff <= nxt_cnt;
         bypass_ff <= nxt_bypass;
         susp_ff <= nxt_susp;
         auto_ff <= nxt_auto;
         erasing_ff <= nxt_erasing;
         ready_ff <= nxt_ready;
         done_ff <= nxt_done;
         refused_ff <= nxt_refused;
         tl_ff <= nxt_tl;
         rdata_ff <= nxt_rdata;
         dq_ff <= nxt_dq;
         addr_ff <= nxt_addr;
         dq_oe_ff <= nxt_dq_oe;
         ce_n_ff <= nxt_ce_n;
         we_n_ff <= nxt_we_n;
         oe_n_ff <= nxt_oe_n;
         byte_n_ff <= nxt_byte_n;
      end
   end

   assign req_ready_out = ready_ff;
   assign done_out = done_ff;
   assign refused_out = refused_ff;
   assign rd_data_out = rdata_ff;
   assign time_limit_flag_out = tl_ff;
   assign bypass_out = bypass_ff;
   assign suspended_out = susp_ff;
   assign autosel_out = auto_ff;
   assign fl_addr_out = addr_ff;
   assign fl_dq_out = dq_ff;
   assign fl_dq_oe_out = dq_oe_ff;
   assign fl_ce_n_out = ce_n_ff;
   assign fl_we_n_out = we_n_ff;
   assign fl_oe_n_out = oe_n_ff;
   assign fl_byte_n_out = byte_n_ff;
endmodule
